/* File: shared/core_regs_pkg.sv */
`default_nettype none
package core_regs_pkg;
  localparam int DATA_W    = 8;
  localparam int PC_W      = 12;
  localparam int PAGE_W    = 6;
  localparam int OFFS_W    = 6;
  localparam int STACK_LVL = 6;

  localparam logic [7:0] WIN_LO_ADDR   = 8'h40;
  localparam logic [7:0] WIN_HI_ADDR   = 8'h7f;
  localparam logic [7:0] PTR0_ADDR     = 8'h80;
  localparam logic [7:0] PTR1_ADDR     = 8'h81;
  localparam logic [7:0] SLOT0_ADDR    = 8'h82;
  localparam logic [7:0] SLOT1_ADDR    = 8'h83;
  localparam logic [7:0] PAGE_ADDR     = 8'hc9;
  localparam logic [7:0] ACC_ADDR      = 8'hff;

  localparam logic [7:0]  DATA_RST     = 8'h00;
  localparam logic [11:0] PC_RST       = 12'h000;
  localparam logic [7:0]  UNDEF_RDATA  = 8'h00;

  localparam int REG_RD_LAT = 1;
  localparam int WIN_RD_LAT = 3;

  typedef enum logic [2:0] {
    PC_HOLD, PC_INC, PC_JUMP, PC_BRANCH, PC_CALL, PC_RET, PC_VECTOR
  } pc_op_e;
endpackage
`default_nettype wire

/* File: shared/core_regs_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface stack_if;
  logic        push;
  logic        pop;
  logic [11:0] pushData;
  logic [11:0] topData;
  logic        empty;
  modport owner (output push, output pop, output pushData, input topData, input empty);
  modport store (input push, input pop, input pushData, output topData, output empty);
endinterface

interface window_if;
  logic        pageWr;
  logic [5:0]  pageData;
  logic        fetch;
  logic [5:0]  offset;
  logic [11:0] romAddr;
  logic        romRdEn;
  modport owner (output pageWr, output pageData, output fetch, output offset,
                 input romAddr, input romRdEn);
  modport win   (input pageWr, input pageData, input fetch, input offset,
                 output romAddr, output romRdEn);
endinterface
`default_nettype wire

/* File: design/return_stack.sv */
`timescale 1ns/1ns
`default_nettype none
module return_stack
  import core_regs_pkg::*;
#(
  parameter int LEVELS = STACK_LVL
) (
  input  wire logic clock,
  input  wire logic rst_b,
  stack_if.store    sif
);
  logic [PC_W-1:0] level_reg [LEVELS];
  logic [3:0]      depth_reg;

  // plain shift chain: no pointer, so an overflowing push simply drops the deepest entry
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      level_reg[0] <= PC_RST;
    end else if (sif.push) begin
      level_reg[0] <= sif.pushData;
    end else if (sif.pop) begin
      level_reg[0] <= level_reg[1];
    end
  end

  for (genvar i = 1; i < LEVELS; i++) begin : g_lvl
    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        level_reg[i] <= PC_RST;
      end else if (sif.push) begin
        level_reg[i] <= level_reg[i-1];
      end else if (sif.pop && i < LEVELS - 1) begin
        level_reg[i] <= level_reg[(i + 1) % LEVELS];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      depth_reg <= 4'h0;
    end else if (sif.push && depth_reg != 4'(LEVELS)) begin
      depth_reg <= depth_reg + 4'h1;
    end else if (sif.pop && depth_reg != 4'h0) begin
      depth_reg <= depth_reg - 4'h1;
    end
  end

  assign sif.topData = level_reg[0];
  assign sif.empty   = (depth_reg == 4'h0);

  a_stack_push: assert property (@(posedge clock) disable iff (!rst_b)
    sif.push |=> level_reg[0] == $past(sif.pushData) && level_reg[1] == $past(level_reg[0]))
    else $error("push did not shift the stack");
endmodule
`default_nettype wire

/* File: design/rom_window.sv */
`timescale 1ns/1ns
`default_nettype none
module rom_window
  import core_regs_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_b,
  window_if.win     wif
);
  logic [PAGE_W-1:0] page_reg;
  logic [PC_W-1:0]   romAddr_reg;
  logic              romRdEn_reg;

  // no reset here: software must load the page before the first window read
  always_ff @(posedge clock) begin
    if (wif.pageWr) begin
      page_reg <= wif.pageData;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      romAddr_reg <= PC_RST;
      romRdEn_reg <= 1'b0;
    end else begin
      romRdEn_reg <= wif.fetch;
      if (wif.fetch) begin
        romAddr_reg <= {page_reg, wif.offset};
      end
    end
  end

  assign wif.romAddr = romAddr_reg;
  assign wif.romRdEn = romRdEn_reg;

  a_page_load: assert property (@(posedge clock) disable iff (!rst_b)
    wif.pageWr ##1 !wif.pageWr ##1 wif.fetch && !wif.pageWr |=> romAddr_reg[11:6] == $past(wif.pageData, 3))
    else $error("window address does not carry the written page");
endmodule
`default_nettype wire

/* File: design/core_data_space_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module core_data_space_regs
  import core_regs_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [7:0]  dsAddr,
  input  wire logic        dsRdEn,
  input  wire logic        dsWrEn,
  input  wire logic [7:0]  dsWrData,
  output logic      [7:0]  dsRdData,
  output logic             dsRdValid,
  input  wire logic        accLoad,
  input  wire logic [7:0]  accIn,
  output logic      [7:0]  accOut,
  input  wire logic        ptrSel,
  output logic      [7:0]  indirectAddr,
  output logic      [7:0]  slot0Out,
  output logic      [7:0]  slot1Out,
  input  wire pc_op_e      pcOp,
  input  wire logic [11:0] pcTarget,
  input  wire logic [7:0]  branchOffset,
  output logic      [11:0] pcOut,
  output logic             stackEmpty,
  output logic      [11:0] romAddr,
  output logic             romRdEn,
  input  wire logic [7:0]  romData
);
  logic [DATA_W-1:0] acc_reg;
  logic [DATA_W-1:0] ptr0_reg;
  logic [DATA_W-1:0] ptr1_reg;
  logic [DATA_W-1:0] slot0_reg;
  logic [DATA_W-1:0] slot1_reg;
  logic [DATA_W-1:0] indirect_reg;
  logic [PC_W-1:0]   pc_reg;
  logic [PC_W-1:0]   pc_next;
  logic [DATA_W-1:0] rdData_reg;
  logic [DATA_W-1:0] rdData_next;
  logic              rdValid_reg;
  logic [1:0]        winPipe_reg;
  logic              stackEmpty_reg;

  stack_if  sif ();
  window_if wif ();

  function automatic logic inWindow(input logic [7:0] a);
    return a >= WIN_LO_ADDR && a <= WIN_HI_ADDR;
  endfunction

  function automatic logic wrHit(input logic we, input logic [7:0] a, input logic [7:0] target);
    return we && a == target;
  endfunction

  // the alu load takes priority over a data-space write to the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg <= DATA_RST;
    end else if (accLoad) begin
      acc_reg <= accIn;
    end else if (wrHit(dsWrEn, dsAddr, ACC_ADDR)) begin
      acc_reg <= dsWrData;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ptr0_reg <= DATA_RST;
      ptr1_reg <= DATA_RST;
    end else begin
      if (wrHit(dsWrEn, dsAddr, PTR0_ADDR)) begin
        ptr0_reg <= dsWrData;
      end
      if (wrHit(dsWrEn, dsAddr, PTR1_ADDR)) begin
        ptr1_reg <= dsWrData;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      slot0_reg <= DATA_RST;
      slot1_reg <= DATA_RST;
    end else begin
      if (wrHit(dsWrEn, dsAddr, SLOT0_ADDR)) begin
        slot0_reg <= dsWrData;
      end
      if (wrHit(dsWrEn, dsAddr, SLOT1_ADDR)) begin
        slot1_reg <= dsWrData;
      end
    end
  end

  // pointer copy lags one cycle so the output stays a plain flop
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      indirect_reg <= DATA_RST;
    end else begin
      indirect_reg <= ptrSel ? ptr1_reg : ptr0_reg;
    end
  end

  // bits 7 and 6 of a page write are simply not wired
  assign wif.pageWr   = wrHit(dsWrEn, dsAddr, PAGE_ADDR);
  assign wif.pageData = dsWrData[PAGE_W-1:0];
  assign wif.fetch    = dsRdEn && inWindow(dsAddr);
  assign wif.offset   = dsAddr[OFFS_W-1:0];

  rom_window u_window (
    .clock (clock),
    .rst_b (rst_b),
    .wif   (wif)
  );

  always_comb begin
    unique case (dsAddr)
      PTR0_ADDR:  rdData_next = ptr0_reg;
      PTR1_ADDR:  rdData_next = ptr1_reg;
      SLOT0_ADDR: rdData_next = slot0_reg;
      SLOT1_ADDR: rdData_next = slot1_reg;
      ACC_ADDR:   rdData_next = acc_reg;
      default:    rdData_next = UNDEF_RDATA;
    endcase
  end

  // window reads wait for the synchronous program memory, so they answer later
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      winPipe_reg <= 2'b00;
    end else begin
      winPipe_reg <= {winPipe_reg[0], wif.romRdEn};
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdData_reg  <= DATA_RST;
      rdValid_reg <= 1'b0;
    end else if (winPipe_reg[0]) begin
      rdData_reg  <= romData;
      rdValid_reg <= 1'b1;
    end else if (dsRdEn && !inWindow(dsAddr)) begin
      rdData_reg  <= rdData_next;
      rdValid_reg <= 1'b1;
    end else begin
      rdValid_reg <= 1'b0;
    end
  end

  always_comb begin
    pc_next      = pc_reg;
    sif.push     = 1'b0;
    sif.pop      = 1'b0;
    sif.pushData = pc_reg;
    unique case (pcOp)
      PC_HOLD:   pc_next = pc_reg;
      PC_INC:    pc_next = pc_reg + 12'h001;
      PC_JUMP:   pc_next = pcTarget;
      PC_BRANCH: pc_next = pc_reg + {{4{branchOffset[7]}}, branchOffset};
      PC_CALL, PC_VECTOR: begin
        pc_next  = pcTarget;
        sif.push = 1'b1;
      end
      PC_RET: begin
        // an empty stack leaves the return in place and runs on
        if (sif.empty) begin
          pc_next = pc_reg + 12'h001;
        end else begin
          pc_next = sif.topData;
          sif.pop = 1'b1;
        end
      end
      default:   pc_next = pc_reg;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pc_reg <= PC_RST;
    end else begin
      pc_reg <= pc_next;
    end
  end

  return_stack u_stack (
    .clock (clock),
    .rst_b (rst_b),
    .sif   (sif)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stackEmpty_reg <= 1'b1;
    end else begin
      stackEmpty_reg <= sif.empty;
    end
  end

  assign dsRdData     = rdData_reg;
  assign dsRdValid    = rdValid_reg;
  assign accOut       = acc_reg;
  assign indirectAddr = indirect_reg;
  assign slot0Out     = slot0_reg;
  assign slot1Out     = slot1_reg;
  assign pcOut        = pc_reg;
  assign stackEmpty   = stackEmpty_reg;
  assign romAddr      = wif.romAddr;
  assign romRdEn      = wif.romRdEn;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_win_req;
    dsRdEn && inWindow(dsAddr);
  endsequence

  sequence s_win_fetch;
    romRdEn ##1 !romRdEn;
  endsequence

  a_win_fetch: assert property (s_win_req |=> romRdEn && romAddr[5:0] == $past(dsAddr[5:0]))
    else $error("window read did not fetch the right offset");

  a_win_answer: assert property (s_win_req ##1 s_win_fetch |=> dsRdValid && dsRdData == $past(romData))
    else $error("window read answer wrong or late");

  a_acc_map: assert property (dsWrEn && dsAddr == ACC_ADDR && !accLoad |=> accOut == $past(dsWrData))
    else $error("accumulator write at ff lost");

  a_ptr_map: assert property (dsWrEn && dsAddr == PTR1_ADDR ##1 !dsWrEn && !dsRdEn
    ##1 dsRdEn && dsAddr == PTR1_ADDR && !dsWrEn |=> dsRdValid && dsRdData == $past(dsWrData, 3))
    else $error("pointer 1 does not read back");

  a_indirect_addr: assert property (ptrSel |=> indirectAddr == $past(ptr1_reg))
    else $error("indirect address not from selected pointer");

  a_slot_map: assert property (dsWrEn && dsAddr == SLOT0_ADDR |=> slot0Out == $past(dsWrData) && slot1Out == $past(slot1Out))
    else $error("short slot write hit wrong register");

  a_pc_step: assert property (pcOp == PC_INC |=> pcOut == $past(pcOut) + 12'h001)
    else $error("program counter did not step");

  a_call_ret: assert property (pcOp == PC_CALL ##1 pcOp == PC_RET |=> pcOut == $past(pcOut, 2))
    else $error("return did not restore the call site");

  a_page_read: assert property (dsRdEn && dsAddr == PAGE_ADDR |=> dsRdValid && dsRdData == UNDEF_RDATA)
    else $error("page register read returned data");

  a_jump_load: assert property (pcOp == PC_JUMP |=> pcOut == $past(pcTarget))
    else $error("jump target not loaded");

  a_branch_add: assert property (pcOp == PC_BRANCH
    |=> pcOut == $past(pcOut) + {{4{$past(branchOffset[7])}}, $past(branchOffset)})
    else $error("branch offset not added");

  // return checks read the live empty flag; vector and call checks read the registered copy, which lags a cycle
  a_vector_load: assert property (pcOp == PC_VECTOR |=> pcOut == $past(pcTarget) ##1 !stackEmpty)
    else $error("vector not loaded or not stacked");

  a_call_push: assert property (pcOp == PC_CALL |=> ##1 !stackEmpty)
    else $error("call left the stack empty");

  a_ret_pop: assert property (pcOp == PC_RET && !sif.empty |=> pcOut == $past(sif.topData))
    else $error("return did not take the top level");

  a_ret_empty: assert property (pcOp == PC_RET && sif.empty |=> pcOut == $past(pcOut) + 12'h001)
    else $error("return on empty stack did not run on");

  a_page_bits: assert property (wif.pageWr |=> u_window.page_reg == $past(dsWrData[PAGE_W-1:0]))
    else $error("page write did not keep the six low bits");

  a_ptr0_map: assert property (dsWrEn && dsAddr == PTR0_ADDR
    |=> ptr0_reg == $past(dsWrData) && ptr1_reg == $past(ptr1_reg))
    else $error("pointer 0 write hit wrong register");

  a_slot1_map: assert property (dsWrEn && dsAddr == SLOT1_ADDR
    |=> slot1Out == $past(dsWrData) && slot0Out == $past(slot0Out))
    else $error("short slot 1 write hit wrong register");

  a_reg_answer: assert property (dsRdEn && !inWindow(dsAddr) && !winPipe_reg[0] |=> dsRdValid)
    else $error("register read gave no answer");

  a_acc_load: assert property (accLoad |=> accOut == $past(accIn))
    else $error("alu result not loaded into accumulator");

  a_rom_strobe: assert property (romRdEn |=> !romRdEn)
    else $error("program memory strobe longer than one cycle");

  a_indirect_ptr0: assert property (!ptrSel |=> indirectAddr == $past(ptr0_reg))
    else $error("indirect address not from pointer 0");
endmodule
`default_nettype wire

/* File: bench/prog_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module prog_mem_model (
  input  wire logic        clock,
  input  wire logic [11:0] romAddr,
  input  wire logic        romRdEn,
  output logic      [7:0]  romData
);
  logic [7:0] memByte_reg = 8'h3c;

  // one-cycle synchronous memory; between reads the lines toggle so a late sample shows
  always_ff @(posedge clock) begin
    if (romRdEn) begin
      memByte_reg <= romAddr[7:0] ^ {romAddr[11:6], 2'b10};
    end else begin
      memByte_reg <= ~memByte_reg;
    end
  end

  assign romData = memByte_reg;
endmodule
`default_nettype wire

/* File: bench/test_core_data_space_regs.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin errCount++; $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp); end end
module test_core_data_space_regs import core_regs_pkg::*;;
  logic        clock;
  logic        rst_b;
  logic [7:0]  dsAddr, dsWrData, dsRdData, accIn, accOut, branchOffset, romData;
  logic        dsRdEn, dsWrEn, dsRdValid, accLoad, ptrSel, stackEmpty, romRdEn, seenEn;
  logic [7:0]  indirectAddr, slot0Out, slot1Out;
  pc_op_e      pcOp;
  logic [11:0] pcTarget, pcOut, romAddr, seenAddr;
  int          errCount, comparisons;

  core_data_space_regs dut (.clock(clock), .rst_b(rst_b), .dsAddr(dsAddr), .dsRdEn(dsRdEn), .dsWrEn(dsWrEn),
    .dsWrData(dsWrData), .dsRdData(dsRdData), .dsRdValid(dsRdValid), .accLoad(accLoad), .accIn(accIn),
    .accOut(accOut), .ptrSel(ptrSel), .indirectAddr(indirectAddr), .slot0Out(slot0Out), .slot1Out(slot1Out),
    .pcOp(pcOp), .pcTarget(pcTarget), .branchOffset(branchOffset), .pcOut(pcOut), .stackEmpty(stackEmpty),
    .romAddr(romAddr), .romRdEn(romRdEn), .romData(romData));
  prog_mem_model mem (.clock(clock), .romAddr(romAddr), .romRdEn(romRdEn), .romData(romData));

  initial clock = 1'b0;
  always #2 clock = ~clock;

  function automatic logic [7:0] rom_byte(input logic [11:0] a);
    return a[7:0] ^ {a[11:6], 2'b10};
  endfunction

  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic ds_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    dsAddr = a;
    dsWrData = d;
    dsWrEn = 1'b1;
    @(negedge clock);
    dsWrEn = 1'b0;
  endtask

  // the page register is never read here: only whole-byte writes reach it
  task automatic ds_read(input logic [7:0] a, output logic [7:0] d, output int lat);
    @(negedge clock);
    dsAddr = a;
    dsRdEn = 1'b1;
    @(negedge clock);
    dsRdEn = 1'b0;
    seenEn = romRdEn;
    seenAddr = romAddr;
    lat = 0;
    while (dsRdValid !== 1'b1 && lat < 8) begin
      @(negedge clock);
      lat++;
    end
    d = dsRdData;
  endtask

  task automatic pc_step(input pc_op_e op, input logic [11:0] t, input logic [7:0] o, input logic [11:0] e);
    @(negedge clock);
    pcOp = op;
    pcTarget = t;
    branchOffset = o;
    @(negedge clock);
    pcOp = PC_HOLD;
    `CHK(pcOut, e)
  endtask

  task automatic test_regs();
    logic [7:0] addrs [5];
    logic [7:0] d;
    int lat;
    addrs = '{PTR0_ADDR, PTR1_ADDR, SLOT0_ADDR, SLOT1_ADDR, ACC_ADDR};
    foreach (addrs[i]) ds_write(addrs[i], 8'ha1 + 8'(i * 17));
    foreach (addrs[i]) begin
      ds_read(addrs[i], d, lat);
      `CHK(d, 8'ha1 + 8'(i * 17))
      `CHK(lat, 0)
      `CHK(seenEn, 1'b0)
    end
    `CHK(slot0Out, 8'hc3)
    `CHK(slot1Out, 8'hd4)
    `CHK(accOut, 8'he5)
    ds_read(8'h90, d, lat);
    `CHK(d, UNDEF_RDATA)
    $display("test_regs done");
  endtask

  task automatic test_indirect();
    logic [7:0] d;
    int lat;
    ds_write(PTR1_ADDR, 8'hb2);
    ds_read(PTR1_ADDR, d, lat);
    `CHK(d, 8'hb2)
    @(negedge clock);
    ptrSel = 1'b0;
    @(negedge clock);
    `CHK(indirectAddr, 8'ha1)
    ptrSel = 1'b1;
    @(negedge clock);
    `CHK(indirectAddr, 8'hb2)
    $display("test_indirect done");
  endtask

  task automatic test_window();
    logic [7:0] pages [3];
    logic [7:0] offs [3];
    logic [7:0] d;
    int lat;
    pages = '{8'hff, 8'h15, 8'h80};
    offs = '{8'h7f, 8'h40, 8'h65};
    foreach (pages[i]) begin
      ds_write(PAGE_ADDR, pages[i]);
      ds_read(offs[i], d, lat);
      `CHK(seenEn, 1'b1)
      `CHK(seenAddr, {pages[i][5:0], offs[i][5:0]})
      `CHK(lat, 2)
      `CHK(d, rom_byte({pages[i][5:0], offs[i][5:0]}))
    end
    $display("test_window done");
  endtask

  task automatic test_acc_priority();
    @(negedge clock);
    dsAddr = ACC_ADDR;
    dsWrData = 8'h22;
    dsWrEn = 1'b1;
    accIn = 8'h11;
    accLoad = 1'b1;
    @(negedge clock);
    dsWrEn = 1'b0;
    accLoad = 1'b0;
    `CHK(accOut, 8'h11)
    $display("test_acc_priority done");
  endtask

  task automatic test_pc();
    pc_step(PC_JUMP, 12'h100, 8'h00, 12'h100);
    pc_step(PC_INC, 12'h000, 8'h00, 12'h101);
    pc_step(PC_BRANCH, 12'h000, 8'hfe, 12'h0ff);
    pc_step(PC_BRANCH, 12'h000, 8'h10, 12'h10f);
    pc_step(PC_JUMP, 12'hfff, 8'h00, 12'hfff);
    pc_step(PC_INC, 12'h000, 8'h00, 12'h000);
    pc_step(PC_JUMP, 12'h100, 8'h00, 12'h100);
    // seven calls: the first return address falls off the bottom
    for (int i = 0; i < 7; i++) pc_step(PC_CALL, 12'h200 + 12'(i), 8'h00, 12'h200 + 12'(i));
    `CHK(stackEmpty, 1'b0)
    for (int i = 0; i < 6; i++) pc_step(PC_RET, 12'h000, 8'h00, 12'h205 - 12'(i));
    pc_step(PC_HOLD, 12'h000, 8'h00, 12'h200);
    `CHK(stackEmpty, 1'b1)
    pc_step(PC_RET, 12'h000, 8'h00, 12'h201);
    pc_step(PC_VECTOR, 12'hff0, 8'h00, 12'hff0);
    pc_step(PC_HOLD, 12'h000, 8'h00, 12'hff0);
    `CHK(stackEmpty, 1'b0)
    pc_step(PC_RET, 12'h000, 8'h00, 12'h201);
    // call and return back to back, no idle cycle between them
    @(negedge clock);
    pcOp = PC_CALL;
    pcTarget = 12'h300;
    @(negedge clock);
    pcOp = PC_RET;
    @(negedge clock);
    pcOp = PC_HOLD;
    `CHK(pcOut, 12'h201)
    $display("test_pc done");
  endtask

  initial begin
    errCount = 0;
    comparisons = 0;
    rst_b = 1'b0;
    dsAddr = 8'h00;
    dsWrData = 8'h00;
    dsRdEn = 1'b0;
    dsWrEn = 1'b0;
    accLoad = 1'b0;
    accIn = 8'h00;
    ptrSel = 1'b0;
    pcOp = PC_HOLD;
    pcTarget = 12'h000;
    branchOffset = 8'h00;
    repeat (20) @(negedge clock);
    `CHK(pcOut, PC_RST)
    `CHK(stackEmpty, 1'b1)
    rst_b = 1'b1;
    test_regs();
    test_indirect();
    test_window();
    test_acc_priority();
    test_pc();
    print_verdict();
  end

  // whole run needs well under a thousand cycles
  initial begin
    #(20000 * 4);
    errCount++;
    print_verdict();
  end
endmodule
`default_nettype wire
